// ===== shared/cmr_pkg.sv
// Register map, field layout, reset values and timing for the control register bank
package cmr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [7:0] PART_ID_HIGH_ADDR = 8'h86;
  localparam logic [7:0] PART_ID_LOW_ADDR  = 8'h87;
  localparam logic [7:0] RESET_CAL_ADDR    = 8'h88;
  localparam logic [7:0] QUICK_ACQ_ADDR    = 8'h89;
  localparam logic [7:0] MON_EN_HIGH_ADDR  = 8'h8a;

  // Field positions
  localparam int unsigned SOFT_RESET_BIT  = 7;
  localparam int unsigned SELF_CAL_BIT    = 6;
  localparam int unsigned QUICK_ACQ_BIT   = 0;
  localparam int unsigned MON_TWO_HI_BIT  = 1;
  localparam int unsigned MON_ONE_HI_BIT  = 0;

  // Reset values
  localparam logic [7:0] RESET_CAL_RESET  = 8'h00;
  localparam logic [7:0] QUICK_ACQ_RESET  = 8'h00;
  localparam logic [7:0] MON_EN_HI_RESET  = 8'h03;
  localparam logic [7:0] UNMAPPED_DATA    = 8'h00;

  // Monitor select encodings
  localparam logic [1:0] MON_OFF      = 2'h0;
  localparam logic [1:0] MON_RESERVED = 2'h1;
  localparam logic [1:0] MON_SLOW     = 2'h2;
  localparam logic [1:0] MON_STANDARD = 2'h3;

  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SOFT_RESET_MS  = 10;
  localparam int unsigned SOFT_RESET_CYCLES = (SOFT_RESET_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CAL_RUN_CYCLES = 64;
  localparam int unsigned SYNC_STAGES    = 3;

  // Calibration sequencer states
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RUN  = 3'b010,
    CAL_LOCK = 3'b100
  } cmr_cal_state_type;
endpackage : cmr_pkg

// ===== src/cmr_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous inputs
`timescale 1ns/1ns
module cmr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] stage_two;
  logic [WIDTH-1:0] stage_three;

  if (WIDTH < 1)
  begin : g_width_check
    $error("cmr_sync WIDTH must be at least 1");
  end

  // Shift chain; stage_one feeds only stage_two
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage_one   <= '0;
      stage_two   <= '0;
      stage_three <= '0;
    end
    else
    begin
      stage_one   <= async_in;
      stage_two   <= stage_one;
      stage_three <= stage_two;
    end
  end

  // Accept a bit only once the later stages agree
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sync_out <= '0;
    else
      for (int i = 0; i < WIDTH; i++)
        if (stage_two[i] == stage_three[i])
          sync_out[i] <= stage_three[i];
  end
endmodule : cmr_sync

// ===== src/cmr_regs.sv
// Control and identification register bank of the clock multiplier
`timescale 1ns/1ns
module cmr_regs
  import cmr_pkg::*;
#(
  parameter logic [11:0] PART_IDENTIFIER       = 12'h0a5, // Arbitrary value
  parameter logic [3:0]  SILICON_REVISION_CODE = 4'h3,    // Arbitrary value
  parameter int unsigned SOFT_RESET_LEN        = SOFT_RESET_CYCLES,
  parameter int unsigned CAL_LEN               = CAL_RUN_CYCLES
) (
  input  wire logic                  clk,
  input  wire logic                  rstn,
  input  wire logic [cmr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [cmr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [cmr_pkg::DATA_W-1:0] reg_rdata,
  output logic                       reg_rvalid,
  input  wire logic [1:0]            mon_sel_low,
  input  wire logic                  pll_lock_detect,
  input  wire logic                  freq_shift_alarm,
  output logic                       clock_output_enable,
  output logic                       soft_reset_active,
  output logic                       pll_unlock_alarm,
  output logic                       calibration_active,
  output logic                       quick_acquire_enable,
  output logic                       bandwidth_boost,
  output logic [1:0]                 input_one_absence_monitor_sel,
  output logic [1:0]                 input_two_absence_monitor_sel,
  output logic [1:0]                 monitor_active,
  output logic [1:0]                 monitor_slow
);
  localparam int unsigned SR_W  = $clog2(SOFT_RESET_LEN + 1);
  localparam int unsigned CAL_W = $clog2(CAL_LEN + 1);

  if (SOFT_RESET_LEN < 1 || CAL_LEN < 1)
  begin : g_param_check
    $error("cmr_regs counts must be at least 1");
  end

  logic [SR_W-1:0]   soft_count;
  logic [CAL_W-1:0]  cal_count;
  logic              self_calibration_start;
  logic [7:0]        quick_acquire_control;
  logic [1:0]        mon_en_high;
  logic [1:0]        sync_level;
  logic              shift_prev;
  logic              auto_cal_req;
  logic              host_cal_req;
  logic              cal_accept;
  logic              soft_trigger;
  logic              wr_reset_cal;
  cmr_cal_state_type cal_state;
  cmr_cal_state_type next_cal_state;

  // Lock and frequency-shift come from other timing domains
  cmr_sync #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({freq_shift_alarm, pll_lock_detect}),
    .sync_out (sync_level)
  );

  assign wr_reset_cal = reg_wr && !soft_reset_active && (reg_addr == RESET_CAL_ADDR);
  assign soft_trigger = wr_reset_cal && reg_wdata[SOFT_RESET_BIT];

  // soft reset hold counter, writes ignored meanwhile
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      soft_reset_active <= 1'b0;
      soft_count        <= '0;
    end
    else if (soft_trigger)
    begin
      soft_reset_active <= 1'b1;
      soft_count        <= SR_W'(SOFT_RESET_LEN);
    end
    else if (soft_count == SR_W'(1))
    begin
      soft_reset_active <= 1'b0;
      soft_count        <= '0;
    end
    else if (soft_count != '0)
      soft_count <= soft_count - SR_W'(1);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      clock_output_enable <= 1'b0;
    else
      clock_output_enable <= !(soft_trigger || soft_reset_active);
  end

  // rising shift alarm requests autonomous calibration
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      shift_prev <= 1'b0;
    else
      shift_prev <= sync_level[1];
  end
  assign auto_cal_req = sync_level[1] && !shift_prev;
  assign host_cal_req = wr_reset_cal && reg_wdata[SELF_CAL_BIT] && !reg_wdata[SOFT_RESET_BIT];
  assign cal_accept   = (cal_state == CAL_IDLE) && (self_calibration_start || auto_cal_req);

  // pending start bit; a new write wins over the clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      self_calibration_start <= RESET_CAL_RESET[SELF_CAL_BIT];
    else if (soft_trigger || soft_reset_active)
      self_calibration_start <= RESET_CAL_RESET[SELF_CAL_BIT];
    else if (host_cal_req)
      self_calibration_start <= 1'b1;
    else if (cal_accept)
      self_calibration_start <= 1'b0;
  end

  // Calibration sequencer next state
  always_comb
  begin
    next_cal_state = cal_state;
    unique case (cal_state)
      CAL_IDLE: if (cal_accept) next_cal_state = CAL_RUN;
      CAL_RUN:  if (cal_count == CAL_W'(1)) next_cal_state = CAL_LOCK;
      CAL_LOCK: if (sync_level[0]) next_cal_state = CAL_IDLE;
      default:  next_cal_state = CAL_IDLE;
    endcase
  end

  // Sequencer state, run counter and alarm
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cal_state          <= CAL_IDLE;
      cal_count          <= '0;
      pll_unlock_alarm   <= 1'b1;
      calibration_active <= 1'b0;
    end
    else if (soft_trigger || soft_reset_active)
    begin
      cal_state          <= CAL_IDLE;
      cal_count          <= '0;
      pll_unlock_alarm   <= 1'b1;
      calibration_active <= 1'b0;
    end
    else
    begin
      cal_state          <= next_cal_state;
      calibration_active <= (next_cal_state != CAL_IDLE);
      if (cal_accept)
        cal_count <= CAL_W'(CAL_LEN);
      else if (cal_count != '0)
        cal_count <= cal_count - CAL_W'(1);
      // alarm drops only when calibration completes
      if (cal_accept)
        pll_unlock_alarm <= 1'b1;
      else if (cal_state == CAL_LOCK && sync_level[0])
        pll_unlock_alarm <= 1'b0;
    end
  end

  // Writable registers; reserved quick-acquire bits kept as written
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      quick_acquire_control <= QUICK_ACQ_RESET;
      mon_en_high           <= MON_EN_HI_RESET[1:0];
    end
    else if (soft_trigger || soft_reset_active)
    begin
      quick_acquire_control <= QUICK_ACQ_RESET;
      mon_en_high           <= MON_EN_HI_RESET[1:0];
    end
    else if (reg_wr)
    begin
      if (reg_addr == QUICK_ACQ_ADDR)
        quick_acquire_control <= reg_wdata;
      // upper select bits stored at 1:0
      if (reg_addr == MON_EN_HIGH_ADDR)
        mon_en_high <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      quick_acquire_enable <= 1'b0;
      bandwidth_boost      <= 1'b0;
    end
    else
    begin
      quick_acquire_enable <= quick_acquire_control[QUICK_ACQ_BIT];
      bandwidth_boost      <= quick_acquire_control[QUICK_ACQ_BIT] && pll_unlock_alarm;
    end
  end

  // decode selects; reserved code treated as off
  // slow flag picks the longer, less sensitive detector
  // low bits come from the mon_sel_low input port
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      input_one_absence_monitor_sel <= MON_STANDARD;
      input_two_absence_monitor_sel <= MON_STANDARD;
      monitor_active                <= 2'h3;
      monitor_slow                  <= 2'h0;
    end
    else
    begin
      input_one_absence_monitor_sel <= {mon_en_high[MON_ONE_HI_BIT], mon_sel_low[0]};
      input_two_absence_monitor_sel <= {mon_en_high[MON_TWO_HI_BIT], mon_sel_low[1]};
      for (int i = 0; i < 2; i++)
      begin
        monitor_active[i] <= mon_en_high[i];
        monitor_slow[i]   <= ({mon_en_high[i], mon_sel_low[i]} == MON_SLOW);
      end
    end
  end

  // Read path, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata  <= UNMAPPED_DATA;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        unique case (reg_addr)
          PART_ID_HIGH_ADDR: reg_rdata <= PART_IDENTIFIER[11:4];
          PART_ID_LOW_ADDR:  reg_rdata <= {PART_IDENTIFIER[3:0], SILICON_REVISION_CODE};
          RESET_CAL_ADDR:    reg_rdata <= {soft_reset_active, self_calibration_start, 6'h00};
          QUICK_ACQ_ADDR:    reg_rdata <= quick_acquire_control;
          MON_EN_HIGH_ADDR:  reg_rdata <= {6'h00, mon_en_high};
          default:           reg_rdata <= UNMAPPED_DATA;
        endcase
      end
    end
  end

  sequence s_host_start;
    reg_wr && !soft_reset_active && reg_addr == RESET_CAL_ADDR
      && reg_wdata[SELF_CAL_BIT] && !reg_wdata[SOFT_RESET_BIT] && cal_state == CAL_IDLE && !cal_accept;
  endsequence

  a_id_high_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == PART_ID_HIGH_ADDR |=> reg_rvalid && reg_rdata == PART_IDENTIFIER[11:4])
    else $error("part identifier high byte wrong");
  a_id_low_read: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && reg_addr == PART_ID_LOW_ADDR |=> reg_rdata == {PART_IDENTIFIER[3:0], SILICON_REVISION_CODE})
    else $error("part identifier low byte wrong");
  a_soft_reset_defaults: assert property (@(posedge clk) disable iff (!rstn)
    soft_trigger |=> soft_reset_active && quick_acquire_control == QUICK_ACQ_RESET
      && mon_en_high == MON_EN_HI_RESET[1:0] && pll_unlock_alarm)
    else $error("soft reset did not restore defaults");
  a_outputs_disabled: assert property (@(posedge clk) disable iff (!rstn)
    soft_reset_active |-> !clock_output_enable)
    else $error("clock outputs enabled during soft reset");
  a_cal_self_clear: assert property (@(posedge clk) disable iff (!rstn)
    s_host_start ##1 !soft_reset_active |=> !self_calibration_start || $past(host_cal_req))
    else $error("calibration start bit did not clear");
  a_cal_done_alarm: assert property (@(posedge clk) disable iff (!rstn)
    $fell(pll_unlock_alarm) |-> $past(cal_state) == CAL_LOCK && $past(sync_level[0]))
    else $error("unlock alarm fell outside calibration end");
  a_auto_cal: assert property (@(posedge clk) disable iff (!rstn)
    auto_cal_req && cal_state == CAL_IDLE && !soft_reset_active && !soft_trigger
      |=> cal_state == CAL_RUN && pll_unlock_alarm)
    else $error("frequency shift did not start calibration");
  a_quick_boost: assert property (@(posedge clk) disable iff (!rstn)
    bandwidth_boost |-> $past(quick_acquire_control[QUICK_ACQ_BIT]) && $past(pll_unlock_alarm))
    else $error("bandwidth boost without quick acquire");
  a_monitor_decode: assert property (@(posedge clk) disable iff (!rstn)
    monitor_slow == {input_two_absence_monitor_sel == MON_SLOW, input_one_absence_monitor_sel == MON_SLOW})
    else $error("slow monitor flag mismatches select");
endmodule : cmr_regs

// ===== testbench/cmr_host_model.sv
// Host controller model driving the parallel register port of the control bank
`timescale 1ns/1ns
module cmr_host_model
  import cmr_pkg::*;
#(
  parameter int unsigned SOFT_WAIT = 24
) (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Idle bus at time zero
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // Released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  // Read data is taken in the cycle the valid pulse stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    d        = reg_rdata;
    ok       = reg_rvalid;
    reg_rd   = 1'b0;
    reg_addr = ~a;
  endtask : rd

  task automatic rmw(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] val);
    logic [7:0] cur;
    logic       ok;
    rd(a, cur, ok);
    wr(a, (cur & ~mask) | (val & mask));
  endtask : rmw

  task automatic soft_reset(input logic [7:0] d);
    wr(RESET_CAL_ADDR, d);
    repeat (SOFT_WAIT) @(negedge clk);
  endtask : soft_reset
endmodule : cmr_host_model

// ===== testbench/tb_top.sv
// Self-checking testbench for the control register bank
`timescale 1ns/1ns
module tb_top;
  import cmr_pkg::*;
  localparam int unsigned SR_LEN = 20;
  localparam int unsigned C_LEN  = 4;
  localparam logic [11:0] PID    = 12'h0a5; // Arbitrary value
  localparam logic [3:0]  REV    = 4'h3;    // Arbitrary value
  logic       clk, rstn, reg_wr, reg_rd, reg_rvalid, pll_lock_detect, freq_shift_alarm;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] mon_sel_low, sel_one, sel_two, monitor_active, monitor_slow;
  logic       clock_output_enable, soft_reset_active, pll_unlock_alarm;
  logic       calibration_active, quick_acquire_enable, bandwidth_boost;
  int         bad_count, checks;

  // Free-running 100 MHz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  cmr_regs #(.PART_IDENTIFIER(PID), .SILICON_REVISION_CODE(REV), .SOFT_RESET_LEN(SR_LEN), .CAL_LEN(C_LEN)) u_dut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mon_sel_low(mon_sel_low),
    .pll_lock_detect(pll_lock_detect), .freq_shift_alarm(freq_shift_alarm),
    .clock_output_enable(clock_output_enable), .soft_reset_active(soft_reset_active),
    .pll_unlock_alarm(pll_unlock_alarm), .calibration_active(calibration_active),
    .quick_acquire_enable(quick_acquire_enable), .bandwidth_boost(bandwidth_boost),
    .input_one_absence_monitor_sel(sel_one), .input_two_absence_monitor_sel(sel_two),
    .monitor_active(monitor_active), .monitor_slow(monitor_slow));

  cmr_host_model #(.SOFT_WAIT(SR_LEN + 4)) u_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Bounded waits that run out end the run here
  task automatic give_up(input string name);
    bad_count++;
    $display("[FAIL] %s expected event seen timeout", name);
    close_out();
  endtask : give_up

  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.rd(a, d, ok);
    chk({name, " valid"}, 8'h01, {7'h0, ok});
    chk(name, exp, d);
  endtask : rchk

  task automatic t_ident();
    rchk("part high", PART_ID_HIGH_ADDR, PID[11:4]);
    rchk("part low rev", PART_ID_LOW_ADDR, {PID[3:0], REV});
    rchk("ctrl reset", RESET_CAL_ADDR, RESET_CAL_RESET);
    rchk("quick reset", QUICK_ACQ_ADDR, QUICK_ACQ_RESET);
    rchk("mon reset", MON_EN_HIGH_ADDR, MON_EN_HI_RESET);
    rchk("unmapped", 8'h8b, UNMAPPED_DATA);
    u_host.wr(PART_ID_HIGH_ADDR, ~PID[11:4]);
    u_host.wr(PART_ID_LOW_ADDR, 8'hff);
    rchk("part high ro", PART_ID_HIGH_ADDR, PID[11:4]);
    rchk("part low ro", PART_ID_LOW_ADDR, {PID[3:0], REV});
    chk("sel one default", 8'h03, {6'h0, sel_one});
    chk("alarm at start", 8'h01, {7'h0, pll_unlock_alarm});
    chk("outputs on", 8'h01, {7'h0, clock_output_enable});
  endtask : t_ident

  task automatic t_quick();
    u_host.rmw(QUICK_ACQ_ADDR, 8'h01, 8'h01);
    repeat (3) @(negedge clk);
    chk("quick enable", 8'h01, {7'h0, quick_acquire_enable});
    chk("boost unlocked", 8'h01, {7'h0, bandwidth_boost});
    rchk("quick readback", QUICK_ACQ_ADDR, 8'h01);
  endtask : t_quick

  // Different codes on the two inputs so a swapped field shows
  task automatic t_monitor();
    logic [1:0] c1;
    logic [1:0] c2;
    for (int c = 0; c < 4; c++)
    begin
      c1 = c[1:0];
      c2 = 2'h3 - c[1:0];
      u_host.wr(MON_EN_HIGH_ADDR, {6'h0, c2[1], c1[1]});
      mon_sel_low = {c2[0], c1[0]};
      repeat (3) @(negedge clk);
      chk("sel one", {6'h0, c1}, {6'h0, sel_one});
      chk("sel two", {6'h0, c2}, {6'h0, sel_two});
      chk("active", {6'h0, c2[1], c1[1]}, {6'h0, monitor_active});
      chk("slow", {6'h0, c2 == MON_SLOW, c1 == MON_SLOW}, {6'h0, monitor_slow});
    end
  endtask : t_monitor

  task automatic t_cal();
    int n;
    u_host.wr(RESET_CAL_ADDR, 8'h40);
    repeat (3) @(negedge clk);
    chk("cal active", 8'h01, {7'h0, calibration_active});
    rchk("start clears", RESET_CAL_ADDR, 8'h00);
    repeat (8) @(negedge clk);
    chk("alarm until lock", 8'h01, {7'h0, pll_unlock_alarm});
    pll_lock_detect = 1'b1;
    for (n = 0; n < 20 && pll_unlock_alarm !== 1'b0; n++) @(negedge clk);
    if (n == 20) give_up("alarm fall");
    repeat (2) @(negedge clk);
    chk("cal done", 8'h00, {7'h0, calibration_active});
    chk("boost off locked", 8'h00, {7'h0, bandwidth_boost});
  endtask : t_cal

  task automatic t_auto();
    int n;
    freq_shift_alarm = 1'b1;
    for (n = 0; n < 12 && pll_unlock_alarm !== 1'b1; n++) @(negedge clk);
    if (n == 12) give_up("auto cal start");
    freq_shift_alarm = 1'b0;
    for (n = 0; n < 30 && pll_unlock_alarm !== 1'b0; n++) @(negedge clk);
    if (n == 30) give_up("auto cal end");
    chk("auto relock", 8'h00, {7'h0, pll_unlock_alarm});
  endtask : t_auto

  // Start bit written with reset bit must not start a calibration
  task automatic t_soft();
    fork
      u_host.soft_reset(8'hc0);
      begin
        repeat (3) @(negedge clk);
        chk("soft flag", 8'h01, {7'h0, soft_reset_active});
        chk("outputs off", 8'h00, {7'h0, clock_output_enable});
        chk("alarm in reset", 8'h01, {7'h0, pll_unlock_alarm});
        chk("quick cleared", 8'h00, {7'h0, quick_acquire_enable});
      end
    join
    chk("soft ended", 8'h00, {7'h0, soft_reset_active});
    chk("outputs back", 8'h01, {7'h0, clock_output_enable});
    chk("no cal", 8'h00, {7'h0, calibration_active});
    rchk("ctrl after", RESET_CAL_ADDR, RESET_CAL_RESET);
    rchk("quick after", QUICK_ACQ_ADDR, QUICK_ACQ_RESET);
    rchk("mon after", MON_EN_HIGH_ADDR, MON_EN_HI_RESET);
  endtask : t_soft

  // Hang guard well above the expected run length
  initial
  begin
    #200000;
    give_up("watchdog");
  end

  initial
  begin
    rstn             = 1'b0;
    mon_sel_low      = 2'h3;
    pll_lock_detect  = 1'b0;
    freq_shift_alarm = 1'b0;
    bad_count        = 0;
    checks           = 0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_ident();
    t_quick();
    t_monitor();
    t_cal();
    t_auto();
    t_soft();
    close_out();
  end
endmodule : tb_top
